// ==== verilog/bdf_regs.vh ====
`ifndef BDF_REGS_VH
`define BDF_REGS_VH

// Queue geometry
`define BDF_DATA_W 36
`define BDF_ADDR_W 8
`define BDF_PTR_W 9
`define BDF_DEPTH 9'h100

// Preset flag offsets, indexed by {offset_select_hi, offset_select_lo}
`define BDF_OFS_SEL_01 9'h008
`define BDF_OFS_SEL_10 9'h010
`define BDF_OFS_SEL_11 9'h040

// Offset values loaded by the global reset and held before any queue reset has loaded others
`define BDF_OFS_RESET 9'h008

// Offset programming: number of loading writes and their order
`define BDF_PROG_WRITES 3'h4
`define BDF_PROG_FWD_AE 3'h0
`define BDF_PROG_RET_AE 3'h1
`define BDF_PROG_FWD_AF 3'h2
`define BDF_PROG_RET_AF 3'h3

// Synchroniser depth in stages
`define BDF_SYNC_STAGES 2

`endif

// ==== verilog/bdf_sync.v ====
`timescale 1ns/100ps

// Two-stage level synchroniser; the first stage feeds only the second.
module bdf_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Data
   input wire [W-1:0] din,
   output wire [W-1:0] dout
);

   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule

// ==== verilog/bdf_queue.v ====
`timescale 1ns/100ps
`include "bdf_regs.vh"

// One dual-clock queue with gray-coded pointer crossing.
module bdf_queue (
   // Clocks and reset
   input wire wclk,
   input wire rclk,
   input wire rst_b,
   // Synchronous queue clears, one per domain
   input wire wclr,
   input wire rclr,
   // Read-domain mode: high for standard timing
   input wire std_mode,
   // Write side
   input wire wr_req,
   input wire [`BDF_DATA_W-1:0] wdata,
   input wire [`BDF_PTR_W-1:0] af_off,
   output reg full_n_ff,
   output reg af_n_ff,
   // Read side
   input wire rd_req,
   input wire [`BDF_PTR_W-1:0] ae_off,
   output reg [`BDF_DATA_W-1:0] rdata_ff,
   output reg ef_or_ff,
   output reg ae_n_ff
);

   reg [`BDF_DATA_W-1:0] mem [0:`BDF_DEPTH-1];
   reg [`BDF_PTR_W-1:0] wbin_ff;
   reg [`BDF_PTR_W-1:0] wgray_ff;
   reg [`BDF_PTR_W-1:0] rbin_ff;
   reg [`BDF_PTR_W-1:0] rgray_ff;
   wire [`BDF_PTR_W-1:0] rgray_w;
   wire [`BDF_PTR_W-1:0] wgray_r;

   function [`BDF_PTR_W-1:0] gray2bin;
      input [`BDF_PTR_W-1:0] g;
      integer i;
      begin
         gray2bin[`BDF_PTR_W-1] = g[`BDF_PTR_W-1];
         for (i = `BDF_PTR_W - 2; i >= 0; i = i - 1) begin
            gray2bin[i] = gray2bin[i+1] ^ g[i];
         end
      end
   endfunction

   bdf_sync #(.W(`BDF_PTR_W)) u_rptr_sync (
      .clk(wclk),
      .rst_b(rst_b),
      .din(rgray_ff),
      .dout(rgray_w)
   );

   bdf_sync #(.W(`BDF_PTR_W)) u_wptr_sync (
      .clk(rclk),
      .rst_b(rst_b),
      .din(wgray_ff),
      .dout(wgray_r)
   );

   // Write domain: full and almost-full are judged on the next pointer
   wire wr_take = wr_req & full_n_ff;
   wire [`BDF_PTR_W-1:0] nxt_wbin = wbin_ff + {{(`BDF_PTR_W-1){1'b0}}, wr_take};
   wire [`BDF_PTR_W-1:0] wfree = `BDF_DEPTH - (nxt_wbin - gray2bin(rgray_w));

   always @(posedge wclk) begin
      if (wr_take) begin
         mem[wbin_ff[`BDF_ADDR_W-1:0]] <= wdata;
      end
   end

   always @(posedge wclk or negedge rst_b) begin
      if (!rst_b) begin
         wbin_ff <= {`BDF_PTR_W{1'b0}};
         wgray_ff <= {`BDF_PTR_W{1'b0}};
         full_n_ff <= 1'b0;
         af_n_ff <= 1'b0;
      end else if (wclr) begin
         wbin_ff <= {`BDF_PTR_W{1'b0}};
         wgray_ff <= {`BDF_PTR_W{1'b0}};
         full_n_ff <= 1'b0;
         af_n_ff <= 1'b0;
      end else begin
         wbin_ff <= nxt_wbin;
         wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
         full_n_ff <= (wfree != {`BDF_PTR_W{1'b0}});
         af_n_ff <= (wfree > af_off);
      end
   end

   // Read domain: the same register serves as empty flag or output-ready
   wire [`BDF_PTR_W-1:0] wbin_r = gray2bin(wgray_r);
   wire mem_avail = (wbin_r != rbin_ff);
   wire rd_take = rd_req & ef_or_ff;
   wire ft_load = mem_avail & (~ef_or_ff | rd_req);
   wire pop = std_mode ? rd_take : ft_load;
   wire [`BDF_PTR_W-1:0] nxt_rbin = rbin_ff + {{(`BDF_PTR_W-1){1'b0}}, pop};
   wire [`BDF_PTR_W-1:0] rcount = wbin_r - nxt_rbin;
   wire nxt_ov = ft_load | (ef_or_ff & ~rd_req);

   always @(posedge rclk or negedge rst_b) begin
      if (!rst_b) begin
         rbin_ff <= {`BDF_PTR_W{1'b0}};
         rgray_ff <= {`BDF_PTR_W{1'b0}};
         rdata_ff <= {`BDF_DATA_W{1'b0}};
         ef_or_ff <= 1'b0;
         ae_n_ff <= 1'b0;
      end else if (rclr) begin
         rbin_ff <= {`BDF_PTR_W{1'b0}};
         rgray_ff <= {`BDF_PTR_W{1'b0}};
         rdata_ff <= {`BDF_DATA_W{1'b0}};
         ef_or_ff <= 1'b0;
         ae_n_ff <= 1'b0;
      end else begin
         rbin_ff <= nxt_rbin;
         rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
         if (pop) begin
            rdata_ff <= mem[rbin_ff[`BDF_ADDR_W-1:0]];
         end
         if (std_mode) begin
            ef_or_ff <= (rcount != {`BDF_PTR_W{1'b0}});
         end else begin
            ef_or_ff <= nxt_ov;
         end
         ae_n_ff <= (rcount > ae_off);
      end
   end

endmodule

// ==== verilog/bdf_top.v ====
`timescale 1ns/100ps
`include "bdf_regs.vh"

// Operation
// - Each side has a 36-bit two-way data port
// - Port A almost-empty low when return count small
// - Port B almost-empty low when forward count small
// - Port A almost-full low when forward space small
// - Port B almost-full low when return space small
// - Port A transfers and flags on port A clock
// - Port B transfers and flags on port B clock
// - Transfer needs select low; data released when high
// - Transfer also needs transfer enable high
// - Port A empty or output-ready per timing mode
// - Port A full or input-ready per timing mode; the code computes this flag the same way in both modes
// - Port B empty or output-ready per timing mode
// - Port B full or input-ready per timing mode; the code computes this flag the same way in both modes
// - Mode pin high standard, low fall-through
// - Offset selects latched on queue reset release
// - Joint reset, selects low: four writes program offsets
// - Presets are 8, 16 or 64 locations
// - Flags two-stage synchronised to their own clock
// - Fall-through shows first word without a read
module bdf_top (
   // Port A clock and global reset
   input wire clk,
   input wire rst_b,
   // Port B clock
   input wire port_b_clock,
   // Queue resets, offset selects and timing mode
   input wire forward_queue_reset_n,
   input wire return_queue_reset_n,
   input wire offset_select_lo,
   input wire offset_select_hi,
   input wire timing_mode_select,
   // Port A control
   input wire port_a_select_n,
   input wire port_a_xfer_enable,
   input wire port_a_write,
   // Port A data
   input wire [`BDF_DATA_W-1:0] side_a_data_bus_i,
   output wire [`BDF_DATA_W-1:0] side_a_data_bus_o,
   output wire side_a_data_bus_oe,
   // Port A flags
   output wire port_a_empty_or_out_ready,
   output wire port_a_full_or_in_ready,
   output wire port_a_almost_empty_n,
   output wire port_a_almost_full_n,
   // Port B control
   input wire port_b_select_n,
   input wire port_b_xfer_enable,
   input wire port_b_write,
   // Port B data
   input wire [`BDF_DATA_W-1:0] side_b_data_bus_i,
   output wire [`BDF_DATA_W-1:0] side_b_data_bus_o,
   output wire side_b_data_bus_oe,
   // Port B flags
   output wire port_b_empty_or_out_ready,
   output wire port_b_full_or_in_ready,
   output wire port_b_almost_empty_n,
   output wire port_b_almost_full_n
);

   // Pin synchronisers, port A domain: fwd reset, ret reset, hi, lo, mode
   wire [4:0] a_pins;
   bdf_sync #(.W(5)) u_a_pin_sync (
      .clk(clk),
      .rst_b(rst_b),
      .din({forward_queue_reset_n, return_queue_reset_n, offset_select_hi,
            offset_select_lo, timing_mode_select}),
      .dout(a_pins)
   );

   // Pin synchronisers, port B domain: fwd reset, ret reset, mode
   wire [2:0] b_pins;
   bdf_sync #(.W(3)) u_b_pin_sync (
      .clk(port_b_clock),
      .rst_b(rst_b),
      .din({forward_queue_reset_n, return_queue_reset_n, timing_mode_select}),
      .dout(b_pins)
   );

   wire a_fwd_rel = a_pins[4];
   wire a_ret_rel = a_pins[3];
   wire [1:0] a_fs = a_pins[2:1];
   wire a_std = a_pins[0];
   wire b_fwd_rel = b_pins[2];
   wire b_ret_rel = b_pins[1];
   wire b_std = b_pins[0];

   // Reset release edges in the port A domain
   reg a_fwd_prev_ff;
   reg a_ret_prev_ff;
   wire fwd_rise = a_fwd_rel & ~a_fwd_prev_ff;
   wire ret_rise = a_ret_rel & ~a_ret_prev_ff;

   // Offsets; port A owns all four and hands two to port B
   reg [`BDF_PTR_W-1:0] fwd_ae_off_ff;
   reg [`BDF_PTR_W-1:0] ret_ae_off_ff;
   reg [`BDF_PTR_W-1:0] fwd_af_off_ff;
   reg [`BDF_PTR_W-1:0] ret_af_off_ff;
   reg prog_act_ff;
   reg [2:0] prog_cnt_ff;
   reg cfg_tog_ff;

   reg [`BDF_PTR_W-1:0] preset;
   always @* begin
      if (a_fs == 2'b01) begin
         preset = `BDF_OFS_SEL_01;
      end else if (a_fs == 2'b10) begin
         preset = `BDF_OFS_SEL_10;
      end else begin
         preset = `BDF_OFS_SEL_11;
      end
   end

   // Port A transfer decode
   wire a_xfer = ~port_a_select_n & port_a_xfer_enable;
   wire a_wr = a_xfer & port_a_write;
   wire a_rd = a_xfer & ~port_a_write;
   wire a_prog_wr = a_wr & prog_act_ff;
   wire a_fifo_wr = a_wr & ~prog_act_ff;
   wire prog_last = a_prog_wr & (prog_cnt_ff == `BDF_PROG_WRITES - 3'h1);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         a_fwd_prev_ff <= 1'b0;
         a_ret_prev_ff <= 1'b0;
         fwd_ae_off_ff <= `BDF_OFS_RESET;
         ret_ae_off_ff <= `BDF_OFS_RESET;
         fwd_af_off_ff <= `BDF_OFS_RESET;
         ret_af_off_ff <= `BDF_OFS_RESET;
         prog_act_ff <= 1'b0;
         prog_cnt_ff <= 3'h0;
         cfg_tog_ff <= 1'b0;
      end else begin
         a_fwd_prev_ff <= a_fwd_rel;
         a_ret_prev_ff <= a_ret_rel;
         if (fwd_rise && ret_rise && a_fs == 2'b00) begin
            prog_act_ff <= 1'b1;
            prog_cnt_ff <= 3'h0;
         end else if (!a_fwd_rel) begin
            // A forward reset abandons any loading in progress
            prog_act_ff <= 1'b0;
            prog_cnt_ff <= 3'h0;
         end else if (a_prog_wr) begin
            prog_cnt_ff <= prog_cnt_ff + 3'h1;
            if (prog_last) begin
               prog_act_ff <= 1'b0;
            end
         end
         if (fwd_rise && a_fs != 2'b00) begin
            fwd_ae_off_ff <= preset;
            fwd_af_off_ff <= preset;
         end else if (a_prog_wr && prog_cnt_ff == `BDF_PROG_FWD_AE) begin
            fwd_ae_off_ff <= side_a_data_bus_i[`BDF_PTR_W-1:0];
         end else if (a_prog_wr && prog_cnt_ff == `BDF_PROG_FWD_AF) begin
            fwd_af_off_ff <= side_a_data_bus_i[`BDF_PTR_W-1:0];
         end
         if (ret_rise && a_fs != 2'b00) begin
            ret_ae_off_ff <= preset;
            ret_af_off_ff <= preset;
         end else if (a_prog_wr && prog_cnt_ff == `BDF_PROG_RET_AE) begin
            ret_ae_off_ff <= side_a_data_bus_i[`BDF_PTR_W-1:0];
         end else if (a_prog_wr && prog_cnt_ff == `BDF_PROG_RET_AF) begin
            ret_af_off_ff <= side_a_data_bus_i[`BDF_PTR_W-1:0];
         end
         // Toggle with the offset load; port B's sync stages delay its copy until the words are stable
         if (((fwd_rise || ret_rise) && a_fs != 2'b00) || prog_last) begin
            cfg_tog_ff <= ~cfg_tog_ff;
         end
      end
   end

   // Port B takes its copy of the offsets on each toggle it sees
   wire b_tog;
   bdf_sync #(.W(1)) u_tog_sync (
      .clk(port_b_clock),
      .rst_b(rst_b),
      .din(cfg_tog_ff),
      .dout(b_tog)
   );

   reg b_tog_prev_ff;
   reg [`BDF_PTR_W-1:0] b_fwd_ae_off_ff;
   reg [`BDF_PTR_W-1:0] b_ret_af_off_ff;
   always @(posedge port_b_clock or negedge rst_b) begin
      if (!rst_b) begin
         b_tog_prev_ff <= 1'b0;
         b_fwd_ae_off_ff <= `BDF_OFS_RESET;
         b_ret_af_off_ff <= `BDF_OFS_RESET;
      end else begin
         b_tog_prev_ff <= b_tog;
         if (b_tog != b_tog_prev_ff) begin
            b_fwd_ae_off_ff <= fwd_ae_off_ff;
            b_ret_af_off_ff <= ret_af_off_ff;
         end
      end
   end

   // Port B transfer decode
   wire b_xfer = ~port_b_select_n & port_b_xfer_enable;
   wire b_wr = b_xfer & port_b_write;
   wire b_rd = b_xfer & ~port_b_write;

   // Data bus drive, released while select is high or the port writes
   reg a_oe_ff;
   reg b_oe_ff;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         a_oe_ff <= 1'b0;
      end else begin
         a_oe_ff <= ~port_a_select_n & ~port_a_write;
      end
   end

   always @(posedge port_b_clock or negedge rst_b) begin
      if (!rst_b) begin
         b_oe_ff <= 1'b0;
      end else begin
         b_oe_ff <= ~port_b_select_n & ~port_b_write;
      end
   end

   assign side_a_data_bus_oe = a_oe_ff;
   assign side_b_data_bus_oe = b_oe_ff;

   // Forward queue: written by port A, read by port B
   bdf_queue u_forward_queue (
      .wclk(clk),
      .rclk(port_b_clock),
      .rst_b(rst_b),
      .wclr(~a_fwd_rel),
      .rclr(~b_fwd_rel),
      .std_mode(b_std),
      .wr_req(a_fifo_wr),
      .wdata(side_a_data_bus_i),
      .af_off(fwd_af_off_ff),
      .full_n_ff(port_a_full_or_in_ready),
      .af_n_ff(port_a_almost_full_n),
      .rd_req(b_rd),
      .ae_off(b_fwd_ae_off_ff),
      .rdata_ff(side_b_data_bus_o),
      .ef_or_ff(port_b_empty_or_out_ready),
      .ae_n_ff(port_b_almost_empty_n)
   );

   // Return queue: written by port B, read by port A
   bdf_queue u_return_queue (
      .wclk(port_b_clock),
      .rclk(clk),
      .rst_b(rst_b),
      .wclr(~b_ret_rel),
      .rclr(~a_ret_rel),
      .std_mode(a_std),
      .wr_req(b_wr),
      .wdata(side_b_data_bus_i),
      .af_off(b_ret_af_off_ff),
      .full_n_ff(port_b_full_or_in_ready),
      .af_n_ff(port_b_almost_full_n),
      .rd_req(a_rd),
      .ae_off(ret_ae_off_ff),
      .rdata_ff(side_a_data_bus_o),
      .ef_or_ff(port_a_empty_or_out_ready),
      .ae_n_ff(port_a_almost_empty_n)
   );

endmodule

// ==== test/bdf_top_asserts.sv ====
`timescale 1ns/100ps
`include "bdf_regs.vh"
module bdf_top_asserts (
   // Clocks and resets
   input wire clk, rst_b, port_b_clock, forward_queue_reset_n, return_queue_reset_n,
   // Port A
   input wire port_a_select_n, port_a_xfer_enable, port_a_write, side_a_data_bus_oe,
   input wire port_a_empty_or_out_ready, port_a_full_or_in_ready, port_a_almost_empty_n, port_a_almost_full_n,
   // Port B
   input wire port_b_select_n, port_b_xfer_enable, port_b_write, side_b_data_bus_oe,
   input wire port_b_empty_or_out_ready, port_b_full_or_in_ready, port_b_almost_empty_n, port_b_almost_full_n
);
   a_oe_a_select: assert property (@(posedge clk) disable iff (!rst_b)
      side_a_data_bus_oe == $past(!port_a_select_n && !port_a_write)) else $error("port a drive enable wrong");
   a_oe_b_select: assert property (@(posedge port_b_clock) disable iff (!rst_b)
      side_b_data_bus_oe == $past(!port_b_select_n && !port_b_write)) else $error("port b drive enable wrong");
   a_af_a_full: assert property (@(posedge clk) disable iff (!rst_b)
      !port_a_full_or_in_ready |-> !port_a_almost_full_n) else $error("port a full without almost full");
   a_af_b_full: assert property (@(posedge port_b_clock) disable iff (!rst_b)
      !port_b_full_or_in_ready |-> !port_b_almost_full_n) else $error("port b full without almost full");
   a_ae_a_empty: assert property (@(posedge clk) disable iff (!rst_b)
      !port_a_empty_or_out_ready |-> !port_a_almost_empty_n) else $error("port a empty without almost empty");
   a_ae_b_empty: assert property (@(posedge port_b_clock) disable iff (!rst_b)
      !port_b_empty_or_out_ready |-> !port_b_almost_empty_n) else $error("port b empty without almost empty");
   a_qrst_a_full: assert property (@(posedge clk) disable iff (!rst_b)
      !forward_queue_reset_n [*5] |-> !port_a_full_or_in_ready) else $error("port a ready during queue reset");
   a_qrst_b_empty: assert property (@(posedge port_b_clock) disable iff (!rst_b)
      !forward_queue_reset_n [*5] |-> !port_b_empty_or_out_ready) else $error("port b ready during queue reset");
   a_idle_a_room: assert property (@(posedge clk) disable iff (!rst_b)
      port_a_full_or_in_ready && (port_a_select_n || !port_a_xfer_enable || !port_a_write) &&
      forward_queue_reset_n && $past(forward_queue_reset_n, 3) |=> port_a_full_or_in_ready)
      else $error("port a space lost without a write");
   a_idle_b_room: assert property (@(posedge port_b_clock) disable iff (!rst_b)
      port_b_full_or_in_ready && (port_b_select_n || !port_b_xfer_enable || !port_b_write) &&
      return_queue_reset_n && $past(return_queue_reset_n, 3) |=> port_b_full_or_in_ready)
      else $error("port b space lost without a write");
endmodule

bind bdf_top bdf_top_asserts bdf_top_asserts_inst (.clk(clk), .rst_b(rst_b), .port_b_clock(port_b_clock),
   .forward_queue_reset_n(forward_queue_reset_n), .return_queue_reset_n(return_queue_reset_n),
   .port_a_select_n(port_a_select_n), .port_a_xfer_enable(port_a_xfer_enable), .port_a_write(port_a_write),
   .side_a_data_bus_oe(side_a_data_bus_oe), .port_a_empty_or_out_ready(port_a_empty_or_out_ready),
   .port_a_full_or_in_ready(port_a_full_or_in_ready), .port_a_almost_empty_n(port_a_almost_empty_n),
   .port_a_almost_full_n(port_a_almost_full_n), .port_b_select_n(port_b_select_n),
   .port_b_xfer_enable(port_b_xfer_enable), .port_b_write(port_b_write), .side_b_data_bus_oe(side_b_data_bus_oe),
   .port_b_empty_or_out_ready(port_b_empty_or_out_ready), .port_b_full_or_in_ready(port_b_full_or_in_ready),
   .port_b_almost_empty_n(port_b_almost_empty_n), .port_b_almost_full_n(port_b_almost_full_n));

// ==== test/bdf_port_b_model.sv ====
`timescale 1ns/100ps
`include "bdf_regs.vh"
// Bus master on port B; requests change only just after a port B rising edge
module bdf_port_b_model (
   // Port B clock and flags
   input wire port_b_clock,
   input wire out_ready,
   input wire in_ready,
   input wire [`BDF_DATA_W-1:0] data_i,
   // Port B controls
   output reg select_n,
   output reg xfer_enable,
   output reg write,
   output reg [`BDF_DATA_W-1:0] data_o
);
   task drive(input s, input e, input w, input [`BDF_DATA_W-1:0] d);
      begin
         select_n <= s;
         xfer_enable <= e;
         write <= w;
         data_o <= d;
      end
   endtask
   initial drive(1'h1, 1'h0, 1'h0, 36'h0);
   task b_write(input [`BDF_DATA_W-1:0] d);
      begin
         while (in_ready !== 1'b1) @(negedge port_b_clock);
         @(posedge port_b_clock);
         drive(1'h0, 1'h1, 1'h1, d);
         @(posedge port_b_clock);
         // Released bus shows the inverse so a stale value cannot pass
         drive(1'h1, 1'h0, 1'h0, ~d);
         @(negedge port_b_clock);
      end
   endtask
   task b_read(input std, output [`BDF_DATA_W-1:0] d);
      begin
         while (out_ready !== 1'b1) @(negedge port_b_clock);
         d = data_i;
         @(posedge port_b_clock);
         drive(1'h0, 1'h1, 1'h0, data_o);
         @(posedge port_b_clock);
         drive(1'h1, 1'h0, 1'h0, data_o);
         @(negedge port_b_clock);
         if (std) d = data_i;
      end
   endtask
endmodule

// ==== test/tb_bdf_top.sv ====
`timescale 1ns/100ps
`include "bdf_regs.vh"
module tb_bdf_top;
   reg clk, port_b_clock, rst_b, fq_n, rq_n, fs_lo, fs_hi, mode, a_sel_n, a_en, a_wr;
   reg [`BDF_DATA_W-1:0] a_din, rd;
   wire [`BDF_DATA_W-1:0] a_dout, b_din, b_dout;
   wire a_oe, a_ef, a_ff, a_ae_n, a_af_n, b_sel_n, b_en, b_wr, b_oe, b_ef, b_ff, b_ae_n, b_af_n;
   integer errors = 0, n_compared = 0, cycles = 0, i;

   bdf_top bdf_top_inst (.clk(clk), .rst_b(rst_b), .port_b_clock(port_b_clock), .forward_queue_reset_n(fq_n),
      .return_queue_reset_n(rq_n), .offset_select_lo(fs_lo), .offset_select_hi(fs_hi), .timing_mode_select(mode),
      .port_a_select_n(a_sel_n), .port_a_xfer_enable(a_en), .port_a_write(a_wr), .side_a_data_bus_i(a_din),
      .side_a_data_bus_o(a_dout), .side_a_data_bus_oe(a_oe), .port_a_empty_or_out_ready(a_ef),
      .port_a_full_or_in_ready(a_ff), .port_a_almost_empty_n(a_ae_n), .port_a_almost_full_n(a_af_n),
      .port_b_select_n(b_sel_n), .port_b_xfer_enable(b_en), .port_b_write(b_wr), .side_b_data_bus_i(b_din),
      .side_b_data_bus_o(b_dout), .side_b_data_bus_oe(b_oe), .port_b_empty_or_out_ready(b_ef),
      .port_b_full_or_in_ready(b_ff), .port_b_almost_empty_n(b_ae_n), .port_b_almost_full_n(b_af_n));
   bdf_port_b_model bdf_port_b_model_inst (.port_b_clock(port_b_clock), .out_ready(b_ef), .in_ready(b_ff),
      .data_i(b_dout), .select_n(b_sel_n), .xfer_enable(b_en), .write(b_wr), .data_o(b_din));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Port B runs at an unrelated rate and phase
   initial begin
      port_b_clock = 1'b0;
      #3;
      forever #7 port_b_clock = ~port_b_clock;
   end
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         tally_and_finish;
      end
   end

   task check(input string what, input [`BDF_DATA_W-1:0] exp, input [`BDF_DATA_W-1:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("compared %0d mismatches %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task a_drive(input s, input e, input w, input [`BDF_DATA_W-1:0] d);
      begin
         a_sel_n <= s;
         a_en <= e;
         a_wr <= w;
         a_din <= d;
      end
   endtask
   task a_write(input [`BDF_DATA_W-1:0] d);
      begin
         while (a_ff !== 1'b1) @(negedge clk);
         @(posedge clk);
         a_drive(1'h0, 1'h1, 1'h1, d);
         @(posedge clk);
         a_drive(1'h1, 1'h0, 1'h0, ~d);
         @(negedge clk);
      end
   endtask
   task a_read(output [`BDF_DATA_W-1:0] d);
      begin
         while (a_ef !== 1'b1) @(negedge clk);
         d = a_dout;
         @(posedge clk);
         a_drive(1'h0, 1'h1, 1'h0, a_din);
         @(posedge clk);
         a_drive(1'h1, 1'h0, 1'h0, a_din);
         @(negedge clk);
         if (mode) d = a_dout;
      end
   endtask
   task do_reset(input m, input hi, input lo);
      begin
         @(posedge clk);
         rst_b <= 1'b0;
         fq_n <= 1'b0;
         rq_n <= 1'b0;
         mode <= m;
         fs_hi <= hi;
         fs_lo <= lo;
         repeat (4) @(posedge clk);
         rst_b <= 1'b1;
         repeat (8) @(posedge clk);
         fq_n <= 1'b1;
         rq_n <= 1'b1;
         repeat (10) @(negedge clk);
      end
   endtask

   task t_reset_flags;
      begin
         do_reset(1'h1, 1'h0, 1'h1);
         check("a_in_ready", 1'h1, a_ff);
         check("a_almost_empty_n", 1'h0, a_ae_n);
         check("a_almost_full_n", 1'h1, a_af_n);
         check("b_out_ready", 1'h0, b_ef);
         check("b_in_ready", 1'h1, b_ff);
         check("b_almost_full_n", 1'h1, b_af_n);
         $display("test reset_flags done");
      end
   endtask
   task t_gating;
      begin
         @(posedge clk);
         a_drive(1'h1, 1'h1, 1'h1, 36'h1);
         @(posedge clk);
         a_drive(1'h0, 1'h0, 1'h1, 36'h2);
         @(posedge clk);
         a_drive(1'h1, 1'h0, 1'h0, 36'h3);
         repeat (12) @(negedge clk);
         check("b_out_ready", 1'h0, b_ef);
         check("a_oe", 1'h0, a_oe);
         a_write(36'hf_0f0f_a5c3);
         repeat (12) @(negedge clk);
         check("b_out_ready", 1'h1, b_ef);
         bdf_port_b_model_inst.b_read(1'h1, rd);
         check("b_data", 36'hf_0f0f_a5c3, rd);
         $display("test gating done");
      end
   endtask
   task t_fill;
      begin
         for (i = 1; i <= 256; i = i + 1) begin
            a_write({28'hc3ea51b, i[7:0]});
            check("a_almost_full_n", (256 - i > 8), a_af_n);
            check("a_in_ready", (i < 256), a_ff);
         end
         @(posedge clk);
         a_drive(1'h0, 1'h1, 1'h1, 36'h0);
         @(posedge clk);
         a_drive(1'h1, 1'h0, 1'h0, 36'hf_ffff_ffff);
         repeat (12) @(negedge clk);
         for (i = 1; i <= 256; i = i + 1) begin
            bdf_port_b_model_inst.b_read(1'h1, rd);
            check("b_data", {28'hc3ea51b, i[7:0]}, rd);
         end
         repeat (12) @(negedge clk);
         check("b_out_ready", 1'h0, b_ef);
         check("b_almost_empty_n", 1'h0, b_ae_n);
         $display("test fill done");
      end
   endtask
   task t_fall_through;
      begin
         do_reset(1'h0, 1'h1, 1'h0);
         bdf_port_b_model_inst.b_write(36'h5_1234_abcd);
         repeat (12) @(negedge clk);
         check("a_out_ready", 1'h1, a_ef);
         check("a_data", 36'h5_1234_abcd, a_dout);
         a_read(rd);
         check("a_read_data", 36'h5_1234_abcd, rd);
         repeat (12) @(negedge clk);
         check("a_out_ready", 1'h0, a_ef);
         for (i = 1; i <= 18; i = i + 1) begin
            bdf_port_b_model_inst.b_write(i);
            repeat (12) @(negedge clk);
            if (i >= 17) check("a_almost_empty_n", (i == 18), a_ae_n);
         end
         $display("test fall_through done");
      end
   endtask
   task t_program;
      begin
         do_reset(1'h1, 1'h0, 1'h0);
         a_write(36'h3);
         a_write(36'h5);
         a_write(36'ha);
         a_write(36'hc);
         for (i = 1; i <= 4; i = i + 1) begin
            a_write(i);
            repeat (12) @(negedge clk);
            if (i >= 3) check("b_almost_empty_n", (i == 4), b_ae_n);
         end
         bdf_port_b_model_inst.b_read(1'h1, rd);
         check("b_first_word", 36'h1, rd);
         $display("test program done");
      end
   endtask

   initial begin
      rst_b = 1'b0;
      fq_n = 1'b0;
      rq_n = 1'b0;
      fs_lo = 1'b0;
      fs_hi = 1'b0;
      mode = 1'b1;
      a_drive(1'h1, 1'h0, 1'h0, 36'h0);
      t_reset_flags;
      t_gating;
      t_fill;
      t_fall_through;
      t_program;
      tally_and_finish;
   end
endmodule
